// File: src/afb_pkg.sv
// Package for the and-with-file and branch-on-carry execution block
package afb_pkg;
   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [5:0] OPC_AND_WORKING_WITH_FILE = 6'h05;
   localparam logic [7:0] OPC_BRANCH_ON_CARRY_SET   = 8'he2;
   localparam logic [7:0] INDEXED_LIMIT             = 8'h5f;
   localparam logic [7:0] ACCESS_SPLIT              = 8'h60;
   localparam logic [3:0] ACCESS_HIGH_BANK          = 4'hf;
   localparam int         OPC_HI_POS                = 10;
   localparam int         DEST_POS                  = 9;
   localparam int         ACCESS_POS                = 8;
   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [20:0] PC_RESET      = 21'h000000;
   localparam logic [7:0]  W_RESET       = 8'h00;
   localparam logic [1:0]  Q_LAST        = 2'h3;
   localparam logic [20:0] PC_STEP       = 21'h000002;

   typedef enum logic [1:0] {
      AFB_ST_EXEC,
      AFB_ST_FLUSH
   } afb_state_e;

   // Data memory request carried as one bundle
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } afb_mem_req_s;

   // Flags written by the block
   typedef struct packed {
      logic neg;
      logic zero;
   } afb_flags_s;
endpackage

// File: src/afb_addr_map.sv
// File operand address mapping for byte-oriented instructions
`timescale 1ns/1ps
`default_nettype none
module afb_addr_map
   import afb_pkg::*;
(
   // Operand fields
   input  wire logic [7:0]  file_i,
   input  wire logic        access_sel_i,
   // Mode and bank state
   input  wire logic        ext_set_i,
   input  wire logic [3:0]  bank_select_register_i,
   input  wire logic [11:0] fsr2_i,
   // Result
   output logic [11:0]      addr_o,
   output logic             indexed_o
);
   always_comb begin
      indexed_o = 1'b0;
      if (access_sel_i) begin
         addr_o = {bank_select_register_i, file_i};
      end else if (ext_set_i && (file_i <= INDEXED_LIMIT)) begin
         indexed_o = 1'b1;
         addr_o    = fsr2_i + {4'h0, file_i};
      end else if (file_i < ACCESS_SPLIT) begin
         addr_o = {4'h0, file_i};
      end else begin
         addr_o = {ACCESS_HIGH_BANK, file_i};
      end
   end
endmodule
`default_nettype wire

// File: src/afb_exec.sv
// Execution unit for and-with-file and branch-on-carry instructions
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Access bit zero, extended set, f<=95: indexed
// - Taken branch adds doubled signed displacement
// - Branch only when carry is set
// - Taken two cycles; not taken one, no write
// - Target is address plus two plus 2n
// - Destination zero to working, one to file
// - Access zero access bank, one uses bank
module afb_exec
   import afb_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_b_i,
   // Instruction stream, presented at Q1 of each cycle
   input  wire logic [15:0]        instr_i,
   input  wire logic               instr_valid_i,
   // Core state
   input  wire logic               carry_i,
   input  wire logic               ext_set_i,
   input  wire logic [3:0]         bank_select_register_i,
   input  wire logic [11:0]        fsr2_i,
   // Data memory
   output afb_pkg::afb_mem_req_s   mem_req_o,
   input  wire logic [7:0]         mem_rdata_i,
   // Results
   output logic [20:0]             pc_o,
   output logic                    pc_write_o,
   output logic [7:0]              working_o,
   output afb_pkg::afb_flags_s     flags_o,
   output logic                    flags_we_o,
   output logic [1:0]              q_phase_o,
   output logic                    nop_cycle_o
);
   import afb_pkg::*;

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_ff;
   logic rst_b_ff;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_ff <= 1'b0;
         rst_b_ff    <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_b_ff    <= rst_meta_ff;
      end
   end

   // ----------------------------------------
   // Q phases and decode
   // ----------------------------------------
   logic [1:0]   q_ff;
   logic [15:0]  ir_ff;
   logic         ir_valid_ff;
   afb_state_e   state_ff;
   logic [20:0]  pc_ff;
   logic [7:0]   w_ff;
   afb_mem_req_s req_ff;
   afb_flags_s   flags_ff;
   logic         flags_we_ff;
   logic         pc_we_ff;
   logic [7:0]   result_ff;

   logic         is_and;
   logic         is_bc;
   logic         take_and;
   logic [11:0]  fa;
   logic [7:0]   nxt_result;
   logic [20:0]  nxt_target;

   function automatic logic [20:0] branch_target(input logic [20:0] pc_next,
                                                 input logic [7:0] disp);
      // Sign-extend and double the displacement
      branch_target = pc_next + {{12{disp[7]}}, disp, 1'b0};
   endfunction

   function automatic logic op_is_and(input logic [15:0] word);
      op_is_and = (word[15:OPC_HI_POS] == OPC_AND_WORKING_WITH_FILE);
   endfunction

   assign is_and   = ir_valid_ff && op_is_and(ir_ff);
   // Decoded from the fetched word itself, so the read already stands in Q2
   assign take_and = instr_valid_i && (state_ff == AFB_ST_EXEC) && op_is_and(instr_i);
   assign is_bc  = ir_valid_ff && (ir_ff[15:8] == OPC_BRANCH_ON_CARRY_SET);
   assign nxt_result = w_ff & mem_rdata_i;
   // pc_ff already holds address plus two while this one executes
   assign nxt_target = branch_target(pc_ff, ir_ff[7:0]);

   afb_addr_map u_map (
      .file_i                 (instr_i[7:0]),
      .access_sel_i           (instr_i[ACCESS_POS]),
      .ext_set_i              (ext_set_i),
      .bank_select_register_i (bank_select_register_i),
      .fsr2_i                 (fsr2_i),
      .addr_o                 (fa),
      .indexed_o              ()
   );

   always_ff @(posedge clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         q_ff <= 2'h0;
      end else begin
         q_ff <= q_ff + 2'h1;
      end
   end

   // Latch instruction at Q1; flush cycle swallows the fetched word
   always_ff @(posedge clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         ir_ff       <= 16'h0000;
         ir_valid_ff <= 1'b0;
      end else if (q_ff == 2'h0) begin
         ir_ff       <= instr_i;
         ir_valid_ff <= instr_valid_i && (state_ff == AFB_ST_EXEC);
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         state_ff <= AFB_ST_EXEC;
      end else if (q_ff == Q_LAST) begin
         if (is_bc && carry_i) begin
            state_ff <= AFB_ST_FLUSH;
         end else begin
            state_ff <= AFB_ST_EXEC;
         end
      end
   end

   // Q2 read of the operand
   always_ff @(posedge clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         req_ff <= '0;
      end else begin
         req_ff.re    <= (q_ff == 2'h0) && take_and;
         req_ff.we    <= 1'b0;
         if (q_ff == 2'h0 && take_and) begin
            req_ff.addr <= fa;
         end
         if (q_ff == 2'h2 && is_and && ir_ff[DEST_POS]) begin
            req_ff.we    <= 1'b1;
            req_ff.wdata <= result_ff;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         result_ff <= 8'h00;
      end else if (q_ff == 2'h1 && is_and) begin
         result_ff <= nxt_result;
      end
   end

   // Q4 writes: working register and flags
   always_ff @(posedge clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         w_ff        <= W_RESET;
         flags_ff    <= '0;
         flags_we_ff <= 1'b0;
      end else begin
         flags_we_ff <= 1'b0;
         if (q_ff == 2'h2 && is_and) begin
            if (!ir_ff[DEST_POS]) begin
               w_ff <= result_ff;
            end
            flags_ff.neg  <= result_ff[7];
            flags_ff.zero <= (result_ff == 8'h00);
            flags_we_ff   <= 1'b1;
         end
      end
   end

   // Program counter: step at Q1, branch write only at Q4 when taken
   always_ff @(posedge clk_i or negedge rst_b_ff) begin
      if (!rst_b_ff) begin
         pc_ff    <= PC_RESET;
         pc_we_ff <= 1'b0;
      end else begin
         pc_we_ff <= 1'b0;
         if (q_ff == 2'h0) begin
            pc_ff <= pc_ff + PC_STEP;
         end else if (q_ff == 2'h2 && is_bc && carry_i) begin
            pc_ff    <= nxt_target;
            pc_we_ff <= 1'b1;
         end
      end
   end

   assign mem_req_o   = req_ff;
   assign pc_o        = pc_ff;
   assign pc_write_o  = pc_we_ff;
   assign working_o   = w_ff;
   assign flags_o     = flags_ff;
   assign flags_we_o  = flags_we_ff;
   assign q_phase_o   = q_ff;
   assign nop_cycle_o = (state_ff == AFB_ST_FLUSH);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_ff);

   branch_target_a: assert property (
      (q_ff == 2'h2 && is_bc && carry_i) |=>
         pc_ff == $past(pc_ff) + {{12{$past(ir_ff[7])}}, $past(ir_ff[7:0]), 1'b0})
      else $error("branch target wrong");
   no_branch_a: assert property (
      (q_ff == 2'h2 && is_bc && !carry_i) |=> !pc_we_ff && pc_ff == $past(pc_ff))
      else $error("untaken branch wrote pc");
   flush_len_a: assert property (
      (q_ff == Q_LAST && is_bc && carry_i) |=> nop_cycle_o [*4] ##1 !nop_cycle_o)
      else $error("flush not one cycle");
   flush_nop_a: assert property (
      (q_ff == 2'h0 && nop_cycle_o) |=> !ir_valid_ff)
      else $error("flush cycle executed");
   and_result_a: assert property (
      (q_ff == 2'h1 && is_and && !ir_ff[DEST_POS]) |=> ##1
         w_ff == ($past(w_ff, 2) & $past(mem_rdata_i, 2)))
      else $error("and result wrong");
   flags_a: assert property (
      flags_we_ff |-> q_ff == Q_LAST && flags_ff.neg == result_ff[7]
         && flags_ff.zero == (result_ff == 8'h00))
      else $error("flag pair inconsistent");
   dest_file_a: assert property (
      (q_ff == 2'h2 && is_and && ir_ff[DEST_POS]) |=>
         req_ff.we && req_ff.wdata == $past(result_ff) && w_ff == $past(w_ff))
      else $error("file write missing");
   bank_addr_a: assert property (
      (q_ff == 2'h0 && take_and && instr_i[ACCESS_POS]) |=>
         req_ff.re && req_ff.addr == {$past(bank_select_register_i), $past(instr_i[7:0])})
      else $error("bank address wrong");
   indexed_a: assert property (
      (q_ff == 2'h0 && take_and && !instr_i[ACCESS_POS] && ext_set_i
         && instr_i[7:0] <= INDEXED_LIMIT) |=>
         req_ff.re && req_ff.addr == $past(fsr2_i) + {4'h0, $past(instr_i[7:0])})
      else $error("indexed address wrong");
   one_cycle_a: assert property (
      (q_ff == Q_LAST && is_and) |=> state_ff == AFB_ST_EXEC)
      else $error("and took two cycles");

   taken_c: cover property (q_ff == 2'h2 && is_bc && carry_i);
   untaken_c: cover property (q_ff == 2'h2 && is_bc && !carry_i);
   and_w_c: cover property (q_ff == 2'h2 && is_and && !ir_ff[DEST_POS]);
   and_f_c: cover property (q_ff == 2'h2 && is_and && ir_ff[DEST_POS]);
endmodule
`default_nettype wire

// File: verif/tb_afb_exec.sv
// Self-checking bench for the and-with-file and branch-on-carry unit
`timescale 1ns/1ps
`default_nettype none
module tb_afb_exec;
   import afb_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic         clk_i                  = 1'b0;
   logic         rst_b_i                = 1'b0;
   logic [15:0]  instr_i                = 16'h0000;
   logic         instr_valid_i          = 1'b0;
   logic         carry_i                = 1'b0;
   logic         ext_set_i              = 1'b0;
   logic [3:0]   bank_select_register_i = 4'h0;
   logic [11:0]  fsr2_i                 = 12'h2a0;
   wire  [7:0]   mem_rdata_i;
   afb_mem_req_s mem_req_o;
   logic [20:0]  pc_o;
   logic         pc_write_o;
   logic [7:0]   working_o;
   afb_flags_s   flags_o;
   logic         flags_we_o;
   logic [1:0]   q_phase_o;
   logic         nop_cycle_o;
   int           fail_count             = 0;
   int           checked                = 0;
   int           cycles                 = 0;

   always #5 clk_i = ~clk_i;
   // Working register starts at zero and only AND writes it, so results stay zero
   assign mem_rdata_i = mem_req_o.addr[7:0] ^ 8'ha5;

   afb_exec dut_u (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
      .carry_i(carry_i), .ext_set_i(ext_set_i),
      .bank_select_register_i(bank_select_register_i), .fsr2_i(fsr2_i),
      .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i), .pc_o(pc_o),
      .pc_write_o(pc_write_o), .working_o(working_o), .flags_o(flags_o),
      .flags_we_o(flags_we_o), .q_phase_o(q_phase_o), .nop_cycle_o(nop_cycle_o));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task summarize;
      $display("counts: checked=%0d mismatches=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task check(input logic [20:0] got, input logic [20:0] exp);
      checked++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask

   task tick;
      @(posedge clk_i);
      #1;
   endtask

   // Bounded wait so a stuck phase counter cannot hang the run
   task sync0;
      int n;
      n = 0;
      while (q_phase_o !== 2'h0 && n < 8) begin
         tick();
         n++;
      end
   endtask

   task and_op(input logic d, input logic a, input logic ext, input logic [3:0] bank_select_register,
               input logic [7:0] f, input logic [11:0] exp_addr);
      sync0();
      ext_set_i = ext;
      bank_select_register_i = bank_select_register;
      instr_i = {OPC_AND_WORKING_WITH_FILE, d, a, f};
      instr_valid_i = 1'b1;
      tick();
      instr_valid_i = 1'b0;
      check(21'(mem_req_o.re), 21'h1);
      check(21'(mem_req_o.addr), 21'(exp_addr));
      tick();
      tick();
      check(21'(flags_we_o), 21'h1);
      check(21'(flags_o), 21'h1);
      check(21'(mem_req_o.we), 21'(d));
      check(21'(working_o), 21'h0);
      if (d) check(21'(mem_req_o.wdata), 21'h0);
      tick();
      check(21'(q_phase_o), 21'h0);
   endtask

   task br_op(input logic c, input logic [7:0] disp);
      logic [20:0] p0;
      logic [20:0] tgt;
      sync0();
      p0 = pc_o;
      tgt = p0 + PC_STEP + {{12{disp[7]}}, disp, 1'b0};
      carry_i = c;
      instr_i = {OPC_BRANCH_ON_CARRY_SET, disp};
      instr_valid_i = 1'b1;
      tick();
      instr_valid_i = 1'b0;
      check(pc_o, p0 + PC_STEP);
      tick();
      tick();
      check(21'(pc_write_o), 21'(c));
      check(pc_o, c ? tgt : p0 + PC_STEP);
      tick();
      check(21'(nop_cycle_o), 21'(c));
      if (c) begin
         // An AND offered in the no-op cycle must be flushed
         instr_i = {OPC_AND_WORKING_WITH_FILE, 1'b1, 1'b1, 8'h33};
         instr_valid_i = 1'b1;
         tick();
         instr_valid_i = 1'b0;
         check(21'(mem_req_o.re), 21'h0);
         tick();
         tick();
         check(21'(nop_cycle_o), 21'h1);
         check(21'(mem_req_o.we), 21'h0);
         tick();
         check(21'(nop_cycle_o), 21'h0);
      end
      carry_i = 1'b0;
   endtask

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk_i);
      #1;
      check(pc_o, PC_RESET);
      check(21'(working_o), 21'(W_RESET));
      rst_b_i = 1'b1;
      repeat (3) tick();
      and_op(1'b0, 1'b0, 1'b1, 4'h3, 8'h5f, 12'h2ff);
      and_op(1'b1, 1'b0, 1'b1, 4'h3, 8'h60, 12'hf60);
      and_op(1'b0, 1'b0, 1'b0, 4'h3, 8'h10, 12'h010);
      and_op(1'b1, 1'b1, 1'b1, 4'h3, 8'h20, 12'h320);
      and_op(1'b0, 1'b1, 1'b0, 4'hc, 8'hff, 12'hcff);
      $display("test and_with_file done");
      br_op(1'b1, 8'h05);
      br_op(1'b0, 8'h05);
      br_op(1'b1, 8'h7f);
      br_op(1'b1, 8'h80);
      br_op(1'b0, 8'h80);
      $display("test branch_on_carry done");
      summarize();
   end

   // Run needs about 65 cycles; ceiling leaves wide margin
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         summarize();
      end
   end
endmodule
`default_nettype wire
